// [common/frame_pkg.sv]
// What this block does
// - crc register starts at all ones before first byte
// - each byte is xored into the low end of the crc register
// - each step shifts right by one, msb filled with zero
// - if the shifted-out bit is one, xor with 0xA001
// - eight shift steps per byte, then the next byte
// - final crc sent as two bytes right after the last byte
// - crc covers address through last data byte, not the check field
// - response repeats the received slave address unchanged
// - error reply is function code plus 0x80, error code, crc
// - unsupported function code answers error code 0x01
// - access past variable address 0xFFFF answers error code 0x02
// - read count of zero or above 125 answers code 0x03
// - state that forbids service answers error code 0x04
// - address not matching unit number is dropped without reply
// - parity, framing, overrun or crc error drops the frame
// - gap of 3.5 characters inside a frame drops it
// - frame longer than the receive buffer is dropped
// - frame shorter than four bytes is dropped
// - length outside the per-function range is dropped
// - address zero is executed but never answered
// - read is code 0x03 with start address then count, two bytes each
// - read counts up to 125 accepted, larger answer code 0x03
// - read reply holds address, 0x03, byte count, data, crc
// - frames are bounded by 3.5 character idle before and after
// - unit number is configurable from 0x01 to 0x63
package frame_pkg;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam int CRC_STEPS = 8;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_ERR_FLAG = 8'h80;
    localparam logic [7:0] EC_FUNC = 8'h01;
    localparam logic [7:0] EC_ADDR = 8'h02;
    localparam logic [7:0] EC_DATA = 8'h03;
    localparam logic [7:0] EC_STATE = 8'h04;
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] UNIT_MIN = 8'h01;
    localparam logic [7:0] UNIT_MAX = 8'h63;
    localparam logic [15:0] READ_MAX = 16'h007D;
    localparam logic [16:0] VAR_LIMIT = 17'h10000;
    localparam int MIN_FRAME = 4;
    localparam int READ_LEN = 8;
    localparam int RX_BUF = 256;
    // 3.5 characters of 11 bits at 9600 baud, in nanoseconds
    localparam int SILENCE_NS = 4010417;
    localparam int CLK_NS = 8;
    localparam int SILENCE_CYC = SILENCE_NS / CLK_NS;
    typedef enum logic [4:0] {
        ST_RX = 5'b00001,
        ST_CHECK = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_SEND = 5'b01000,
        ST_CRC = 5'b10000
    } state_t;
endpackage

// [common/crc_if.sv]
`timescale 1ns/1ps
// byte-wise crc engine port group
interface crc_if;
    logic clear;
    logic feed;
    logic [7:0] data;
    logic [15:0] crc;
    modport engine (input clear, input feed, input data, output crc);
    modport user (output clear, output feed, output data, input crc);
endinterface

// [hw/crc16_unit.sv]
`timescale 1ns/1ps
module crc16_unit
    import frame_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // byte port
    crc_if.engine cif
);
    logic [15:0] crc_q;
    logic [15:0] crc_d;

    // one whole byte per cycle: eight unrolled shift steps
    always_comb begin
        crc_d = crc_q ^ {8'h00, cif.data};
        for (int i = 0; i < CRC_STEPS; i++) begin
            if (crc_d[0]) begin
                crc_d = (crc_d >> 1) ^ CRC_POLY;
            end else begin
                crc_d = crc_d >> 1;
            end
        end
    end

    // =========================================
    // working register
    always_ff @(posedge clk) begin
        if (srst || cif.clear) begin
            crc_q <= CRC_PRESET;
        end else if (cif.feed) begin
            crc_q <= crc_d;
        end
    end

    assign cif.crc = crc_q;
endmodule

// [hw/rtu_frame_handler.sv]
`timescale 1ns/1ps
module rtu_frame_handler
    import frame_pkg::*;
#(
    parameter int SILENCE = SILENCE_CYC,
    parameter int BUF_DEPTH = RX_BUF
)(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // configuration
    input wire logic [7:0] unit_number,
    input wire logic service_blocked,
    // receive bytes from the uart
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_error,
    // variable area read port
    output logic var_req,
    output logic [15:0] var_addr,
    input wire logic var_ack,
    input wire logic [15:0] var_data,
    // transmit bytes to the uart
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // frame events
    output logic exec_read,
    output logic frame_dropped
);
    state_t state_q;
    logic [7:0] buf_q [BUF_DEPTH];
    logic [8:0] len_q;
    logic bad_q;
    logic [31:0] idle_q;
    logic [7:0] fc_q;
    logic [7:0] ec_q;
    logic err_q;
    logic [7:0] idx_q;
    logic [7:0] nbytes_q;
    logic [15:0] word_q;
    logic [15:0] next_addr_q;
    logic crc_hi_q;
    // two-entry transmit buffer
    logic [7:0] ob_data_q [2];
    logic [1:0] ob_cnt_q;
    logic ob_wr_q;
    logic ob_rd_q;
    logic push;
    logic [7:0] push_byte;
    logic ob_ready;
    crc_if rx_crc ();
    crc_if tx_crc ();

    crc16_unit u_rx_crc (
        .clk(clk),
        .srst(srst),
        .cif(rx_crc.engine)
    );
    crc16_unit u_tx_crc (
        .clk(clk),
        .srst(srst),
        .cif(tx_crc.engine)
    );

    // =========================================
    // receive side
    logic silent;
    assign silent = (idle_q >= 32'(SILENCE));

    // idle counter: restarts on each byte, saturates at silence
    always_ff @(posedge clk) begin
        if (srst) begin
            idle_q <= '0;
        end else if (rx_valid) begin
            idle_q <= '0;
        end else if (!silent) begin
            idle_q <= idle_q + 32'd1;
        end
    end

    // crc over everything received; with check bytes included a good
    // frame leaves zero in the register
    assign rx_crc.clear = (state_q == ST_RX) && silent && rx_valid ? 1'b0
                        : (state_q != ST_RX);
    assign rx_crc.feed = rx_valid && (state_q == ST_RX);
    assign rx_crc.data = rx_data;

    // byte capture; a byte after silence in ST_RX starts a new frame, but one in the first silent cycle joins the pending frame
    always_ff @(posedge clk) begin
        if (srst) begin
            len_q <= '0;
            bad_q <= 1'b0;
        end else if (state_q == ST_RX && rx_valid) begin
            if (len_q < 9'(BUF_DEPTH)) begin
                buf_q[len_q[7:0]] <= rx_data;
                len_q <= len_q + 9'd1;
            end else begin
                bad_q <= 1'b1;
            end
            if (rx_error) begin
                bad_q <= 1'b1;
            end
        end else if (state_q == ST_CHECK) begin
            len_q <= '0;
            bad_q <= 1'b0;
        end
    end

    // =========================================
    // frame checks and reply decision
    logic addr_ok;
    logic len_ok;
    logic [15:0] start_w;
    logic [15:0] count_w;
    assign addr_ok = (buf_q[0] == unit_number && unit_number >= UNIT_MIN
                      && unit_number <= UNIT_MAX)
                     || buf_q[0] == ADDR_BCAST;
    assign len_ok = len_q >= 9'(MIN_FRAME)
                    && len_q <= 9'(BUF_DEPTH);
    assign start_w = {buf_q[2], buf_q[3]};
    assign count_w = {buf_q[4], buf_q[5]};

    // state machine
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_RX;
            fc_q <= '0;
            ec_q <= '0;
            err_q <= 1'b0;
            exec_read <= 1'b0;
            frame_dropped <= 1'b0;
            idx_q <= '0;
            nbytes_q <= '0;
            next_addr_q <= '0;
            crc_hi_q <= 1'b0;
            var_req <= 1'b0;
            var_addr <= '0;
            word_q <= '0;
        end else begin
            exec_read <= 1'b0;
            frame_dropped <= 1'b0;
            case (state_q)
                ST_RX: begin
                    // checks wait for end-of-frame silence
                    if (silent && len_q != 9'd0) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    state_q <= ST_RX;
                    fc_q <= buf_q[1];
                    err_q <= 1'b1;
                    idx_q <= '0;
                    if (bad_q || !len_ok || !addr_ok ||
                        rx_crc.crc != 16'h0000) begin
                        frame_dropped <= 1'b1;
                    end else if (buf_q[1] != FC_READ) begin
                        ec_q <= EC_FUNC;
                        state_q <= (buf_q[0] == ADDR_BCAST) ? ST_RX : ST_SEND;
                    end else if (len_q != 9'(READ_LEN)) begin
                        frame_dropped <= 1'b1;
                    end else begin
                        if (service_blocked) begin
                            ec_q <= EC_STATE;
                        end else if (count_w == 16'h0000 ||
                                     count_w > READ_MAX) begin
                            ec_q <= EC_DATA;
                        end else if ({1'b0, start_w} + {1'b0, count_w}
                                     > VAR_LIMIT) begin
                            ec_q <= EC_ADDR;
                        end else begin
                            err_q <= 1'b0;
                            exec_read <= 1'b1;
                            nbytes_q <= 8'({count_w[6:0], 1'b0});
                            next_addr_q <= start_w;
                        end
                        // broadcast runs but never answers
                        state_q <= (buf_q[0] == ADDR_BCAST) ? ST_RX
                                 : ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (push) begin
                        idx_q <= idx_q + 8'd1;
                        if (!err_q && idx_q >= 8'd3 && idx_q[0]) begin
                            word_q <= {word_q[7:0], 8'h00};
                        end
                        if ((err_q && idx_q == 8'd2) ||
                            (!err_q && idx_q == nbytes_q + 8'd2)) begin
                            state_q <= ST_CRC;
                            crc_hi_q <= 1'b0;
                        end else if (!err_q && idx_q >= 8'd2 &&
                                     !idx_q[0]) begin
                            state_q <= ST_FETCH;
                            var_req <= 1'b1;
                            var_addr <= next_addr_q;
                        end
                    end
                end
                ST_FETCH: begin
                    if (var_ack) begin
                        var_req <= 1'b0;
                        word_q <= var_data;
                        next_addr_q <= next_addr_q + 16'd1;
                        state_q <= ST_SEND;
                    end
                end
                ST_CRC: begin
                    if (push) begin
                        crc_hi_q <= 1'b1;
                        if (crc_hi_q) begin
                            state_q <= ST_RX;
                        end
                    end
                end
                default: state_q <= ST_RX;
            endcase
        end
    end

    // =========================================
    // reply byte selection
    always_comb begin
        push_byte = 8'h00;
        if (state_q == ST_CRC) begin
            push_byte = crc_hi_q ? tx_crc.crc[15:8]
                                 : tx_crc.crc[7:0];
        end else if (idx_q == 8'd0) begin
            push_byte = buf_q[0];
        end else if (idx_q == 8'd1) begin
            push_byte = err_q ? (fc_q | FC_ERR_FLAG) : fc_q;
        end else if (idx_q == 8'd2) begin
            push_byte = err_q ? ec_q : nbytes_q;
        end else begin
            push_byte = word_q[15:8];
        end
    end

    assign push = ob_ready && (state_q == ST_SEND || state_q == ST_CRC);
    // crc covers the header and data but not the check bytes
    assign tx_crc.clear = (state_q == ST_CHECK);
    assign tx_crc.feed = push && state_q == ST_SEND;
    assign tx_crc.data = push_byte;

    // =========================================
    // two-entry output buffer; a stalled uart back-pressures the
    // sequencer so no reply byte is lost
    assign ob_ready = (ob_cnt_q != 2'd2);

    always_ff @(posedge clk) begin
        if (srst) begin
            ob_cnt_q <= '0;
            ob_wr_q <= 1'b0;
            ob_rd_q <= 1'b0;
        end else begin
            if (push) begin
                ob_data_q[ob_wr_q] <= push_byte;
                ob_wr_q <= ~ob_wr_q;
            end
            if (tx_valid && tx_ready) begin
                ob_rd_q <= ~ob_rd_q;
            end
            ob_cnt_q <= ob_cnt_q + 2'(push) - 2'(tx_valid && tx_ready);
        end
    end

    // registered head of the buffer
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_valid <= 1'b0;
            tx_data <= '0;
        end else begin
            if (tx_valid && tx_ready) begin
                tx_valid <= (ob_cnt_q == 2'd2) || push;
                tx_data <= (ob_cnt_q == 2'd2) ? ob_data_q[~ob_rd_q]
                                              : push_byte;
            end else if (!tx_valid && (ob_cnt_q != 2'd0 || push)) begin
                tx_valid <= 1'b1;
                tx_data <= (ob_cnt_q != 2'd0) ? ob_data_q[ob_rd_q]
                                              : push_byte;
            end
        end
    end
endmodule

// [testbench/frame_props.sv]
`timescale 1ns/1ps
// ================================================
// port checks for the frame handler
module frame_props
    import frame_pkg::*;
#(
    parameter int SILENCE = 50
)(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // configuration and receive side
    input wire logic [7:0] unit_number,
    input wire logic service_blocked,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // outputs under watch
    input wire logic var_req,
    input wire logic [15:0] var_addr,
    input wire logic var_ack,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic exec_read,
    input wire logic frame_dropped
);
    int idle_q;
    logic [7:0] addr_q;
    logic [7:0] fc_q;
    logic [1:0] n_q;
    logic [1:0] pos_q;
    // quiet time since the last received byte, saturating
    always_ff @(posedge clk) begin
        if (srst)
            idle_q <= SILENCE;
        else if (rx_valid)
            idle_q <= 0;
        else if (idle_q < SILENCE)
            idle_q <= idle_q + 1;
    end
    // first two bytes of each frame, split by silence; unlike the design, a byte in the first silent cycle starts a new frame
    always_ff @(posedge clk) begin
        if (srst) begin
            n_q <= 2'h0;
            addr_q <= 8'h00;
            fc_q <= 8'h00;
        end else if (rx_valid && idle_q >= SILENCE) begin
            addr_q <= rx_data;
            n_q <= 2'h1;
        end else if (rx_valid && n_q == 2'h1) begin
            fc_q <= rx_data;
            n_q <= 2'h2;
        end
    end
    // position of the reply byte being handed over
    always_ff @(posedge clk) begin
        if (srst || rx_valid)
            pos_q <= 2'h0;
        else if (tx_valid && tx_ready && pos_q != 2'h3)
            pos_q <= pos_q + 2'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_take;
        tx_valid && tx_ready;
    endsequence
    AST_TX_STAND: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data)) else $error("reply byte moved");
    AST_REQ_STAND: assert property (var_req && !var_ack |=>
        var_req && $stable(var_addr)) else $error("read request moved");
    AST_LATE_EXEC: assert property (exec_read |->
        idle_q >= SILENCE - 1) else $error("execute before silence");
    AST_LATE_DROP: assert property (frame_dropped |->
        idle_q >= SILENCE - 1) else $error("drop before silence");
    AST_FIRST_TX: assert property ($rose(tx_valid) |->
        idle_q >= SILENCE - 1) else $error("reply before silence");
    AST_ADDR_OK: assert property (tx_valid |->
        addr_q == unit_number && addr_q != ADDR_BCAST)
        else $error("reply to foreign or broadcast address");
    AST_ECHO: assert property (s_take ##0 pos_q == 2'h0 |->
        tx_data == addr_q) else $error("address not echoed");
    AST_FC_ERR: assert property (s_take ##0 pos_q == 2'h1
        ##0 fc_q != FC_READ |-> tx_data == (fc_q | FC_ERR_FLAG))
        else $error("error flag missing");
    AST_BLOCKED: assert property (s_take ##0 pos_q == 2'h2
        ##0 service_blocked |-> tx_data == EC_STATE)
        else $error("state error code wrong");
    AST_DROP_QUIET: assert property (frame_dropped |=>
        !tx_valid [*8]) else $error("reply after drop");
endmodule
bind rtu_frame_handler frame_props #(.SILENCE(SILENCE)) chk (
    .clk(clk), .srst(srst), .unit_number(unit_number),
    .service_blocked(service_blocked), .rx_valid(rx_valid),
    .rx_data(rx_data), .var_req(var_req), .var_addr(var_addr),
    .var_ack(var_ack), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .exec_read(exec_read),
    .frame_dropped(frame_dropped));

// [testbench/host_model.sv]
`timescale 1ns/1ps
// ================================================
// serial host: sends framed commands, collects replies
module host_model #(
    parameter int SILENCE = 50
)(
    // clock
    input wire logic clk,
    // bytes towards the device
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_error,
    // reply bytes
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // stall control
    input wire logic slow
);
    logic [7:0] got[$];
    logic [2:0] tick_q = 3'h0;
    // slow mode takes one byte in eight to stress the reply buffer
    always @(posedge clk) tick_q <= tick_q + 3'h1;
    assign tx_ready = !slow || tick_q == 3'h0;
    always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_error = 1'b0;
    end
    // bytewise check code
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            repeat (8)
                c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // gap applies after the second byte; cx corrupts the check code
    task automatic send_frame(input logic [7:0] f[$], input int gap,
        input int err_at, input logic [15:0] cx);
        logic [15:0] c;
        c = crc16(f) ^ cx;
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(posedge clk);
            #1 rx_valid = 1'b1;
            rx_data = f[i];
            rx_error = (i == err_at);
            @(posedge clk);
            #1 rx_valid = 1'b0;
            rx_data = ~f[i]; // released line shows no stale byte
            rx_error = 1'b0;
            repeat (i == 1 ? gap : 2) @(posedge clk);
        end
        repeat (SILENCE + 2) @(posedge clk);
    endtask
endmodule

// [testbench/rtu_frame_handler_tb_top.sv]
`timescale 1ns/1ps
// ================================================
// frame handler bench
module rtu_frame_handler_tb_top;
    import frame_pkg::*;
    localparam int SIL = 50;
    typedef logic [7:0] bq_t[$];
    typedef struct packed {
        logic [7:0] u, a, fc;
        logic [15:0] st, n;
        logic blk;
        logic [7:0] ex;
    } row_t;
    logic clk, srst, blk, slow, rx_valid, rx_error, var_req, var_ack;
    logic tx_valid, tx_ready, exec_read, frame_dropped;
    logic [7:0] unit, rx_data, tx_data;
    logic [15:0] var_addr, var_data, crc_w;
    int bad_count = 0, cmp_count = 0, cyc = 0, n_exec = 0, n_drop = 0;
    row_t rows[10];
    bq_t none, f;
    rtu_frame_handler #(.SILENCE(SIL), .BUF_DEPTH(256)) dut (
        .clk(clk), .srst(srst), .unit_number(unit),
        .service_blocked(blk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_error(rx_error), .var_req(var_req), .var_addr(var_addr),
        .var_ack(var_ack), .var_data(var_data), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .exec_read(exec_read),
        .frame_dropped(frame_dropped));
    host_model #(.SILENCE(SIL)) host (.clk(clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_error(rx_error), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .slow(slow));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // variable area answers two cycles late, word is address ^ 5A3C
    initial begin
        var_ack = 1'b0;
        var_data = 16'h0000;
        forever begin
            @(posedge clk);
            #1;
            if (var_req) begin
                repeat (2) @(posedge clk);
                #1 var_ack = 1'b1;
                var_data = var_addr ^ 16'h5A3C;
                @(posedge clk);
                #1 var_ack = 1'b0;
                var_data = ~var_data;
                @(posedge clk);
            end
        end
    end
    // event counters and hang limit
    always @(posedge clk) begin
        cyc++;
        if (exec_read === 1'b1) n_exec++;
        if (frame_dropped === 1'b1) n_drop++;
        if (cyc == 40000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic check(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic bq_t cmd(row_t r);
        bq_t q;
        q = '{r.a, r.fc, r.st[15:8], r.st[7:0], r.n[15:8], r.n[7:0]};
        return q;
    endfunction
    function automatic bq_t rsp(row_t r);
        bq_t e;
        logic [15:0] w, c;
        if (r.ex == 8'hFF) return e;
        if (r.ex == 8'h00) begin
            e = '{r.a, r.fc, {r.n[6:0], 1'b0}};
            for (int i = 0; i < r.n; i++) begin
                w = (r.st + 16'(i)) ^ 16'h5A3C;
                e.push_back(w[15:8]);
                e.push_back(w[7:0]);
            end
        end else
            e = '{r.a, r.fc | FC_ERR_FLAG, r.ex};
        c = host.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        return e;
    endfunction
    task automatic xfer(input bq_t q, e, input int gap, err,
        input logic [15:0] cx, input int ex_n, dr_n);
        int e0, d0, k;
        host.got.delete();
        e0 = n_exec;
        d0 = n_drop;
        host.send_frame(q, gap, err, cx);
        k = 0;
        while (host.got.size() < e.size() && k < 3000) begin
            @(posedge clk);
            k++;
        end
        repeat (SIL) @(posedge clk);
        #1;
        check("reply length", host.got.size(), e.size());
        foreach (e[i])
            if (i < host.got.size())
                check("reply byte", host.got[i], e[i]);
        check("exec pulses", n_exec - e0, ex_n);
        check("drop pulses", n_drop - d0, dr_n);
        $display("test done, %0d reply bytes", e.size());
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ================================================
    // main sequence
    initial begin
        srst = 1'b1;
        unit = 8'h11;
        blk = 1'b0;
        slow = 1'b0;
        rows = '{
            '{8'h11, 8'h11, 8'h03, 16'h1010, 16'h0001, 1'b0, 8'h00},
            '{8'h11, 8'h11, 8'h03, 16'hFFFF, 16'h0001, 1'b0, 8'h00},
            '{8'h11, 8'h11, 8'h03, 16'hFFFF, 16'h0002, 1'b0, 8'h02},
            '{8'h63, 8'h63, 8'h03, 16'h0000, 16'h007D, 1'b0, 8'h00},
            '{8'h63, 8'h63, 8'h03, 16'h0000, 16'h007E, 1'b0, 8'h03},
            '{8'h01, 8'h01, 8'h03, 16'h0010, 16'h0000, 1'b0, 8'h03},
            '{8'h01, 8'h01, 8'h10, 16'h0010, 16'h0001, 1'b0, 8'h01},
            '{8'h01, 8'h01, 8'h03, 16'h0010, 16'h0001, 1'b1, 8'h04},
            '{8'h01, 8'h05, 8'h03, 16'h0010, 16'h0001, 1'b0, 8'hFF},
            '{8'h01, 8'h00, 8'h03, 16'h0010, 16'h0001, 1'b0, 8'hFF}};
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        check("idle reply", tx_valid, 1'b0);
        f = '{8'h01, 8'h03, 8'h10, 8'h10, 8'h00, 8'h01};
        crc_w = host.crc16(f);
        // low byte goes out first, so the wire order reads 81 then 0F
        check("check code", {crc_w[7:0], crc_w[15:8]}, 16'h810F);
        foreach (rows[i]) begin
            unit = rows[i].u;
            blk = rows[i].blk;
            slow = i[0];
            xfer(cmd(rows[i]), rsp(rows[i]), 2, -1, 16'h0000,
                int'(rows[i].ex == 8'h00 || rows[i].a == 8'h00),
                int'(rows[i].ex == 8'hFF && rows[i].a != 8'h00));
        end
        unit = 8'h11;
        blk = 1'b0;
        xfer(cmd(rows[0]), none, 2, -1, 16'h0001, 0, 1);
        xfer(cmd(rows[0]), none, 2, 3, 16'h0000, 0, 1);
        xfer(cmd(rows[0]), none, SIL + 5, -1, 16'h0000, 0, 2);
        xfer('{8'h11}, none, 2, -1, 16'h0000, 0, 1);
        f = cmd(rows[0]);
        f.push_back(8'h00);
        xfer(f, none, 2, -1, 16'h0000, 0, 1);
        repeat (300) f.push_back(8'h00);
        xfer(f, none, 2, -1, 16'h0000, 0, 1);
        // reset in mid reply must silence both outputs
        unit = 8'h63;
        slow = 1'b1;
        host.send_frame(cmd(rows[3]), 2, -1, 16'h0000);
        #1 srst = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("reset tx", tx_valid, 1'b0);
        check("reset req", var_req, 1'b0);
        srst = 1'b0;
        unit = 8'h11;
        xfer(cmd(rows[0]), rsp(rows[0]), 2, -1, 16'h0000, 1, 0);
        end_of_test();
    end
endmodule
